// ===== logic/gpm_port.v
// one general-purpose i/o port with address-masked data access and pin interrupts
// What this block does
// RULE1: direction 0 captures pin into data
// RULE2: direction 1 drives data bit out
// RULE3: address bits 9..2 mask data accesses
// RULE4: data register seen at 256 locations
// RULE5: masked write changes only unmasked bits
// RULE6: masked read returns zero for masked bits
// RULE7: all pin causes form one interrupt
// RULE8: edge interrupt latched until software clears
// RULE9: level source holds level until recognized
// RULE10: sense bit chooses edge or level
// RULE11: both-edges bit triggers either edge
// RULE12: polarity bit picks low/falling or high/rising
// RULE13: mask bit gates raw onto output
// RULE14: raw status ignores the mask
// RULE15: masked status is raw and mask
// RULE16: clear write one clears, zero ignored
// RULE17: software masks before changing trigger setup
// RULE18: alternate select hands pin to peripheral
// RULE19: reset gives inputs, debug pins alternate
// RULE20: pad drive, pulls, open drain, slew, enable
// RULE21: software enables port clock before use
// RULE22: read-only identification registers
// RULE23: data writes touch only output pins
// RULE24: pins pass two-flop synchroniser first
`timescale 1ns/1ps
`include "gpm_consts.vh"

module gpm_port #(
  parameter       W          = 8,
  parameter [7:0] AFSEL_RST  = 8'h00,
  parameter [7:0] ID0        = 8'h11,
  parameter [7:0] ID1        = 8'h22,
  parameter [7:0] ID2        = 8'h33,
  parameter [7:0] ID3        = 8'h44
) (
  input  wire                   clk_i,
  input  wire                   resetn_i,
  input  wire [`GPM_ADDR_W-1:0] addr_i,
  input  wire [31:0]            wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [31:0]            rdata_o,
  input  wire [W-1:0]           pin_i,
  output reg  [W-1:0]           pin_o,
  output reg  [W-1:0]           pin_oe_o,
  input  wire [W-1:0]           periph_out_i,
  input  wire [W-1:0]           periph_oe_i,
  output reg  [W-1:0]           periph_in_o,
  output reg                    irq_o,
  output reg  [W-1:0]           drive_2ma_o,
  output reg  [W-1:0]           drive_4ma_o,
  output reg  [W-1:0]           drive_8ma_o,
  output reg  [W-1:0]           open_drain_o,
  output reg  [W-1:0]           pull_up_o,
  output reg  [W-1:0]           pull_down_o,
  output reg  [W-1:0]           slew_ctl_o,
  output reg  [W-1:0]           dig_en_o
);

  // ********************************
  // helpers
  // ********************************
  // mask sits in the address bits above the word offset
  function [W-1:0] addr_mask;
    input [`GPM_ADDR_W-1:0] a;
    begin
      addr_mask = a[`GPM_MASK_LSB +: W];
    end
  endfunction

  // unused upper bits of every word read as zero
  function [31:0] zext;
    input [W-1:0] v;
    begin
      zext = {{(32-W){1'b0}}, v};
    end
  endfunction

  // ********************************
  // drive strength select
  // ********************************
  // ones written to one strength clear them in the other two,
  // so a pad never sees two drive strengths at once
  function [W-1:0] drv_upd;
    input [W-1:0] cur;
    input [W-1:0] bits;
    input         own;
    begin
      if (own)
        drv_upd = cur | bits;
      else
        drv_upd = cur & ~bits;
    end
  endfunction

  // ********************************
  // pin synchroniser
  // ********************************
  reg [W-1:0] sync1_reg;
  reg [W-1:0] sync2_reg;
  reg [W-1:0] prev_reg;

  // chain resets to zero: a pulled-up pin shows one rising edge
  // after release, harmless while polarity still resets to falling;
  // prev_reg only feeds the edge compare
  // RULE24: two-flop synchroniser
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= {W{1'b0}};
      sync2_reg <= {W{1'b0}};
      prev_reg  <= {W{1'b0}};
    end
    else
    begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // ********************************
  // registers
  // ********************************
  reg [W-1:0] data_reg;
  reg [W-1:0] dir_reg;
  reg [W-1:0] is_reg;
  reg [W-1:0] ibe_reg;
  reg [W-1:0] iev_reg;
  reg [W-1:0] im_reg;
  reg [W-1:0] edge_reg;
  reg [W-1:0] af_reg;
  reg [W-1:0] dr2_reg;
  reg [W-1:0] dr4_reg;
  reg [W-1:0] dr8_reg;
  reg [W-1:0] odr_reg;
  reg [W-1:0] pur_reg;
  reg [W-1:0] pdr_reg;
  reg [W-1:0] slr_reg;
  reg [W-1:0] den_reg;

  // every word of the data window reaches data_reg
  wire data_hit = (addr_i >= `GPM_DATA_LO) && (addr_i <= `GPM_DATA_HI);
  wire wr_data  = wr_i && data_hit;
  wire [W-1:0] wmask = addr_mask(addr_i);
  wire [W-1:0] wd    = wdata_i[W-1:0];

  // RULE1: inputs captured from synchronised pins, gated by digital enable
  wire [W-1:0] pin_in = sync2_reg & den_reg;

  // RULE5: masked write of output bits only
  // RULE23: inputs ignore writes
  wire [W-1:0] wr_bits = wmask & dir_reg & {W{wr_data}};

  // data_next keeps outputs, follows pins on inputs
  wire [W-1:0] data_next = (dir_reg & ~wr_bits & data_reg) | (wr_bits & wd)
                         | (~dir_reg & pin_in);

  // ********************************
  // interrupt detection
  // ********************************
  // RULE10: sense chooses edge or level
  // RULE11: both edges or single
  // RULE12: polarity selects high/rising or low/falling
  wire [W-1:0] rise     = sync2_reg & ~prev_reg;
  wire [W-1:0] fall     = ~sync2_reg & prev_reg;
  wire [W-1:0] edge_hit = (ibe_reg & (rise | fall))
                        | (~ibe_reg & ((iev_reg & rise) | (~iev_reg & fall)));
  wire [W-1:0] lvl_hit  = ~(sync2_reg ^ iev_reg);
  wire [W-1:0] icr_bits = (wr_i && addr_i == `GPM_ICR_OFF) ? wd : {W{1'b0}};
  // RULE8: edge latched until cleared; set wins
  // RULE16: clear by writing ones
  wire [W-1:0] edge_next = (edge_reg & ~icr_bits) | (~is_reg & edge_hit);
  // RULE14: raw ignores mask
  wire [W-1:0] raw = (~is_reg & edge_reg) | (is_reg & lvl_hit);
  // RULE15: masked status
  // RULE13: mask gates raw
  wire [W-1:0] mis = raw & im_reg;

  // ********************************
  // pad output mux
  // ********************************
  // alternate function owns value and enable of its pins
  wire [W-1:0] out_val = (af_reg & periph_out_i) | (~af_reg & data_reg);
  wire [W-1:0] out_en  = (af_reg & periph_oe_i) | (~af_reg & dir_reg);
  // open drain: a one releases the pad, the pull brings it high
  wire [W-1:0] oe_eff  = out_en & ~(odr_reg & out_val);

  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_reg <= `GPM_RST_ZERO;
      // RULE19: inputs with alternate off except debug pins
      dir_reg  <= `GPM_RST_ZERO;
      af_reg   <= AFSEL_RST;
      is_reg   <= `GPM_RST_ZERO;
      ibe_reg  <= `GPM_RST_ZERO;
      iev_reg  <= `GPM_RST_ZERO;
      im_reg   <= `GPM_RST_ZERO;
      edge_reg <= `GPM_RST_ZERO;
      dr2_reg  <= `GPM_RST_DR2;
      dr4_reg  <= `GPM_RST_ZERO;
      dr8_reg  <= `GPM_RST_ZERO;
      odr_reg  <= `GPM_RST_ZERO;
      pur_reg  <= `GPM_RST_PUR;
      pdr_reg  <= `GPM_RST_ZERO;
      slr_reg  <= `GPM_RST_ZERO;
      den_reg  <= `GPM_RST_DEN;
    end
    else
    begin
      // RULE3: address mask applied
      // RULE4: all 256 words hit one register
      data_reg <= data_next;
      edge_reg <= edge_next;
      if (wr_i)
      begin
        if (addr_i == `GPM_DIR_OFF)
          dir_reg <= wd;
        else if (addr_i == `GPM_IS_OFF)
          is_reg <= wd;
        else if (addr_i == `GPM_IBE_OFF)
          ibe_reg <= wd;
        else if (addr_i == `GPM_IEV_OFF)
          iev_reg <= wd;
        else if (addr_i == `GPM_IM_OFF)
          im_reg <= wd;
        else if (addr_i == `GPM_AFSEL_OFF)
          af_reg <= wd;
        // RULE20: drive selects are mutually exclusive
        else if (addr_i == `GPM_DR2_OFF)
        begin
          dr2_reg <= drv_upd(dr2_reg, wd, 1'b1);
          dr4_reg <= drv_upd(dr4_reg, wd, 1'b0);
          dr8_reg <= drv_upd(dr8_reg, wd, 1'b0);
        end
        else if (addr_i == `GPM_DR4_OFF)
        begin
          dr2_reg <= drv_upd(dr2_reg, wd, 1'b0);
          dr4_reg <= drv_upd(dr4_reg, wd, 1'b1);
          dr8_reg <= drv_upd(dr8_reg, wd, 1'b0);
        end
        else if (addr_i == `GPM_DR8_OFF)
        begin
          dr2_reg <= drv_upd(dr2_reg, wd, 1'b0);
          dr4_reg <= drv_upd(dr4_reg, wd, 1'b0);
          dr8_reg <= drv_upd(dr8_reg, wd, 1'b1);
        end
        else if (addr_i == `GPM_ODR_OFF)
          odr_reg <= wd;
        else if (addr_i == `GPM_PUR_OFF)
          pur_reg <= wd;
        else if (addr_i == `GPM_PDR_OFF)
          pdr_reg <= wd;
        else if (addr_i == `GPM_SLR_OFF)
          slr_reg <= wd;
        else if (addr_i == `GPM_DEN_OFF)
          den_reg <= wd;
        // status, clear and ident words have no storage here
      end
    end
  end

  // ********************************
  // read path
  // ********************************
  reg [31:0] rd_next;
  always @*
  begin
    rd_next = 32'h0000_0000;
    if (!rd_i)
      rd_next = 32'h0000_0000;
    // RULE6: masked bits read zero
    else if (data_hit)
      rd_next = zext(data_reg & addr_mask(addr_i));
    else if (addr_i == `GPM_DIR_OFF)
      rd_next = zext(dir_reg);
    else if (addr_i == `GPM_IS_OFF)
      rd_next = zext(is_reg);
    else if (addr_i == `GPM_IBE_OFF)
      rd_next = zext(ibe_reg);
    else if (addr_i == `GPM_IEV_OFF)
      rd_next = zext(iev_reg);
    else if (addr_i == `GPM_IM_OFF)
      rd_next = zext(im_reg);
    // level causes read live; only edges are latched,
    // so a level source must hold until software has looked
    else if (addr_i == `GPM_RIS_OFF)
      rd_next = zext(raw);
    else if (addr_i == `GPM_MIS_OFF)
      rd_next = zext(mis);
    else if (addr_i == `GPM_AFSEL_OFF)
      rd_next = zext(af_reg);
    else if (addr_i == `GPM_DR2_OFF)
      rd_next = zext(dr2_reg);
    else if (addr_i == `GPM_DR4_OFF)
      rd_next = zext(dr4_reg);
    else if (addr_i == `GPM_DR8_OFF)
      rd_next = zext(dr8_reg);
    else if (addr_i == `GPM_ODR_OFF)
      rd_next = zext(odr_reg);
    else if (addr_i == `GPM_PUR_OFF)
      rd_next = zext(pur_reg);
    else if (addr_i == `GPM_PDR_OFF)
      rd_next = zext(pdr_reg);
    else if (addr_i == `GPM_SLR_OFF)
      rd_next = zext(slr_reg);
    else if (addr_i == `GPM_DEN_OFF)
      rd_next = zext(den_reg);
    // RULE22: fixed identification words
    else if (addr_i == `GPM_ID0_OFF)
      rd_next = {24'h000000, ID0};
    else if (addr_i == `GPM_ID1_OFF)
      rd_next = {24'h000000, ID1};
    else if (addr_i == `GPM_ID2_OFF)
      rd_next = {24'h000000, ID2};
    else if (addr_i == `GPM_ID3_OFF)
      rd_next = {24'h000000, ID3};
    // other ident words and unmapped offsets read zero
  end

  // ********************************
  // outputs
  // ********************************
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_o      <= 32'h0000_0000;
      pin_o        <= {W{1'b0}};
      pin_oe_o     <= {W{1'b0}};
      periph_in_o  <= {W{1'b0}};
      irq_o        <= 1'b0;
      drive_2ma_o  <= `GPM_RST_DR2;
      drive_4ma_o  <= `GPM_RST_ZERO;
      drive_8ma_o  <= `GPM_RST_ZERO;
      open_drain_o <= `GPM_RST_ZERO;
      pull_up_o    <= `GPM_RST_PUR;
      pull_down_o  <= `GPM_RST_ZERO;
      slew_ctl_o   <= `GPM_RST_ZERO;
      dig_en_o     <= `GPM_RST_DEN;
    end
    else
    begin
      rdata_o <= rd_next;
      // RULE18: alternate function owns the pin
      // RULE2: outputs driven from data
      pin_o <= out_val;
      // open drain drives only low
      pin_oe_o <= oe_eff;
      periph_in_o <= pin_in;
      // RULE7: one port interrupt
      irq_o <= |mis;
      drive_2ma_o  <= dr2_reg;
      drive_4ma_o  <= dr4_reg;
      drive_8ma_o  <= dr8_reg;
      open_drain_o <= odr_reg;
      pull_up_o    <= pur_reg;
      pull_down_o  <= pdr_reg;
      // slew only meaningful at 8 ma
      slew_ctl_o   <= slr_reg & dr8_reg;
      dig_en_o     <= den_reg;
    end
  end

endmodule

// ===== logic/gpm_consts.vh
// register offsets, reset values and identification constants of the gpio port
`ifndef GPM_CONSTS_VH
`define GPM_CONSTS_VH

`define GPM_ADDR_W        12
`define GPM_DATA_LO       12'h000
`define GPM_DATA_HI       12'h3fc
`define GPM_DIR_OFF       12'h400
`define GPM_IS_OFF        12'h404
`define GPM_IBE_OFF       12'h408
`define GPM_IEV_OFF       12'h40c
`define GPM_IM_OFF        12'h410
`define GPM_RIS_OFF       12'h414
`define GPM_MIS_OFF       12'h418
`define GPM_ICR_OFF       12'h41c
`define GPM_AFSEL_OFF     12'h420
`define GPM_DR2_OFF       12'h500
`define GPM_DR4_OFF       12'h504
`define GPM_DR8_OFF       12'h508
`define GPM_ODR_OFF       12'h50c
`define GPM_PUR_OFF       12'h510
`define GPM_PDR_OFF       12'h514
`define GPM_SLR_OFF       12'h518
`define GPM_DEN_OFF       12'h51c
`define GPM_ID_LO         12'hfd0
`define GPM_ID_HI         12'hffc
`define GPM_ID0_OFF       12'hfe0
`define GPM_ID1_OFF       12'hfe4
`define GPM_ID2_OFF       12'hfe8
`define GPM_ID3_OFF       12'hfec

`define GPM_MASK_MSB      9
`define GPM_MASK_LSB      2

`define GPM_RST_ZERO      8'h00
`define GPM_RST_DR2       8'hff
`define GPM_RST_PUR       8'hff
`define GPM_RST_DEN       8'hff

`endif

// ===== test/gpm_port_chk.sv
// concurrent checks on the gpio port bus and pins
`timescale 1ns/1ps
module gpm_port_chk #(
  parameter       W   = 8,
  parameter [7:0] ID0 = 8'h11
) (
  input wire         clk_i,
  input wire         resetn_i,
  input wire [11:0]  addr_i,
  input wire [31:0]  wdata_i,
  input wire         wr_i,
  input wire         rd_i,
  input wire [31:0]  rdata_o,
  input wire [W-1:0] pin_i,
  input wire [W-1:0] pin_oe_o,
  input wire [W-1:0] periph_in_o,
  input wire         irq_o,
  input wire [W-1:0] drive_2ma_o,
  input wire [W-1:0] drive_4ma_o,
  input wire [W-1:0] drive_8ma_o,
  input wire [W-1:0] slew_ctl_o,
  input wire [W-1:0] dig_en_o
);
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero");
  chk_read_mask: assert property ($past(rd_i) && $past(addr_i[11:10]) == 2'h0
    |-> (rdata_o & ~{24'h0, $past(addr_i[9:2])}) == 32'h0) else $error("mask leak");
  chk_ident_read: assert property ($past(rd_i) && $past(addr_i) == 12'hfe0
    |-> rdata_o == {24'h0, ID0}) else $error("ident wrong");
  chk_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) == 12'h600
    |-> rdata_o == 32'h0) else $error("unmapped not zero");
  chk_drive_onehot: assert property ((drive_2ma_o & drive_4ma_o) == '0
    && (drive_8ma_o & (drive_2ma_o | drive_4ma_o)) == '0) else $error("drives overlap");
  chk_slew_gated: assert property ((slew_ctl_o & ~drive_8ma_o) == '0)
    else $error("slew without 8ma");
  chk_irq_masked: assert property (wr_i && addr_i == 12'h410 && wdata_i[W-1:0] == '0
    |-> ##2 !irq_o) else $error("irq while masked");
  chk_reset_inputs: assert property ($rose(resetn_i)
    |-> pin_oe_o == '0 && &dig_en_o && &drive_2ma_o) else $error("reset state");
  chk_sync_follow: assert property ($stable(pin_i) [*4] ##0 &dig_en_o
    |-> periph_in_o == pin_i) else $error("pin level lost");
  cov_masked_read: cover property (rd_i && addr_i == 12'h0c4);
  cov_irq_rise: cover property ($rose(irq_o));
  cov_clear: cover property (wr_i && addr_i == 12'h41c);
endmodule

bind gpm_port gpm_port_chk #(.W(W), .ID0(ID0)) chk_u (.clk_i(clk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pin_i(pin_i), .pin_oe_o(pin_oe_o), .periph_in_o(periph_in_o), .irq_o(irq_o),
  .drive_2ma_o(drive_2ma_o), .drive_4ma_o(drive_4ma_o), .drive_8ma_o(drive_8ma_o),
  .slew_ctl_o(slew_ctl_o), .dig_en_o(dig_en_o));

// ===== test/gpm_pin_model.sv
// outside world on the port pins: sources, pull-ups, floating lines
`timescale 1ns/1ps
module gpm_pin_model #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire [W-1:0] pad_out_i,
  input  wire [W-1:0] pad_oe_i,
  input  wire [W-1:0] pull_up_i,
  input  wire [W-1:0] ext_val_i,
  input  wire [W-1:0] ext_en_i,
  output reg  [W-1:0] lvl_o
);
  // floating lines wander so no stale level passes
  reg     [W-1:0] drift_q = '0;
  integer         i;
  always @(posedge clk_i)
    drift_q <= ~drift_q;
  // source level held as long as told
  always @*
    for (i = 0; i < W; i = i + 1)
      lvl_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] : pull_up_i[i] | drift_q[i];
endmodule

// ===== test/gpm_port_bench.sv
// self-checking bench for the gpio port
`timescale 1ns/1ps
module gpm_port_bench;
  localparam [7:0]  ID_A = 8'h5a; // arbitrary ident value
  localparam [95:0] ROFF = {12'h600, 12'hfe0, 12'h51c, 12'h510,
                            12'h504, 12'h500, 12'h420, 12'h400};
  localparam [63:0] REXP = {8'h00, ID_A, 8'hff, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00};
  reg        clk_i = 1'b0;
  reg        resetn_i = 1'b0;
  reg [11:0] addr_i = 12'h0;
  reg [31:0] wdata_i = 32'h0;
  reg        wr_i = 1'b0;
  reg        rd_i = 1'b0;
  reg [7:0]  p_out = 8'h0;
  reg [7:0]  p_oe = 8'h0;
  reg [7:0]  ext_val = 8'h0;
  reg [7:0]  ext_en = 8'h0;
  wire [31:0] rdata_o;
  wire [7:0]  lvl, pin_o, pin_oe_o, pur, slr;
  wire        irq_o;
  int         error_cnt = 0;
  int         checked = 0;

  gpm_port #(.ID0(ID_A)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(lvl),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .periph_out_i(p_out), .periph_oe_i(p_oe),
    .periph_in_o(), .irq_o(irq_o), .drive_2ma_o(), .drive_4ma_o(), .drive_8ma_o(),
    .open_drain_o(), .pull_up_o(pur), .pull_down_o(), .slew_ctl_o(slr), .dig_en_o());
  gpm_pin_model pins_u (.clk_i(clk_i), .pad_out_i(pin_o), .pad_oe_i(pin_oe_o),
    .pull_up_i(pur), .ext_val_i(ext_val), .ext_en_i(ext_en), .lvl_o(lvl));

  initial
    forever #10 clk_i = ~clk_i;

  // ****
  // bus tasks
  // ****
  task automatic cmp(input string what, input [7:0] exp, input [7:0] seen);
    checked = checked + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s exp %h got %h", what, exp, seen);
    end
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input [11:0] a, input [7:0] exp, input string what);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 cmp(what, exp, rdata_o[7:0]);
    @(posedge clk_i);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task give_verdict;
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #50000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end

  // ****
  // scenarios
  // ****
  initial
  begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    // port clock runs before first access
    @(posedge clk_i);
    for (int i = 0; i < 8; i++)
      rd(ROFF[12*i +: 12], REXP[8*i +: 8], "reset map");
    ext_en <= 8'hff;
    ext_val <= 8'ha0;
    wr(12'h400, 32'hff);
    wr(12'h3fc, 32'h55);
    idle(2);
    cmp("pin out", 8'h55, pin_o);
    wr(12'h098, 32'heb);
    rd(12'h3fc, 8'h73, "masked write");
    rd(12'h0c4, 8'h31, "masked read");
    wr(12'h400, 32'h0f);
    wr(12'h3fc, 32'hff);
    idle(4);
    rd(12'h3fc, 8'haf, "in out mix");
    p_oe <= 8'h01;
    p_out <= 8'h02;
    wr(12'h420, 32'h03);
    idle(2);
    cmp("alt oe", 8'h0d, pin_oe_o);
    cmp("alt out", 8'h0e, pin_o & 8'h0f);
    wr(12'h420, 32'h00);
    ext_val <= 8'h02;
    wr(12'h400, 32'h00);
    wr(12'h410, 32'h00);
    wr(12'h404, 32'h18);
    wr(12'h408, 32'h04);
    wr(12'h40c, 32'h09);
    idle(4);
    wr(12'h41c, 32'hff);
    rd(12'h414, 8'h10, "raw level low");
    ext_val <= 8'h0f;
    idle(4);
    rd(12'h414, 8'h1d, "raw rising");
    ext_val <= 8'h0d;
    idle(4);
    rd(12'h414, 8'h1f, "raw falling");
    rd(12'h418, 8'h00, "masked none");
    cmp("irq off", 8'h00, {7'h0, irq_o});
    wr(12'h410, 32'h01);
    idle(2);
    rd(12'h418, 8'h01, "masked one");
    cmp("irq on", 8'h01, {7'h0, irq_o});
    wr(12'h41c, 32'h00);
    rd(12'h414, 8'h1f, "clear zero");
    wr(12'h41c, 32'h01);
    idle(2);
    rd(12'h414, 8'h1e, "cleared");
    cmp("irq gone", 8'h00, {7'h0, irq_o});
    ext_val <= 8'h0c;
    idle(4);
    rd(12'h414, 8'h1e, "other edge");
    ext_val <= 8'h0d;
    idle(4);
    rd(12'h414, 8'h1f, "edge again");
    ext_val <= 8'h05;
    idle(4);
    rd(12'h414, 8'h17, "level gone");
    wr(12'h508, 32'h01);
    wr(12'h518, 32'hff);
    rd(12'h500, 8'hfe, "drive swap");
    cmp("slew", 8'h01, slr);
    give_verdict;
  end
endmodule
